// [hdl/input_path_cfg_pkg.sv]
package input_path_cfg_pkg;

   // ----------------------------------------
   // Register indices (byte address = 4 * index)
   // ----------------------------------------
   localparam logic [11:0] IDX_HPF_CUT = 12'h30C;
   localparam logic [11:0] IDX_P1_SHARED = 12'h310;
   localparam logic [11:0] IDX_P1R_CTRL = 12'h314;
   localparam logic [11:0] IDX_P1R_VOLSRC = 12'h315;
   localparam logic [11:0] IDX_P1R_DELAY = 12'h316;
   localparam logic [11:0] IDX_P2_CTRL = 12'h318;
   localparam logic [11:0] IDX_P2_VOLSRC = 12'h319;
   localparam logic [11:0] IDX_P2_DELAY = 12'h31A;

   // ----------------------------------------
   // Field positions and widths
   // ----------------------------------------
   localparam int HPF_EN_BIT = 15;
   localparam int OSR_LSB = 13;
   localparam int OSR_W = 2;
   localparam int SUP_LSB = 11;
   localparam int SUP_W = 2;
   localparam int MODE_BIT = 10;
   localparam int GAIN_LSB = 1;
   localparam int GAIN_W = 7;
   localparam int SRC_LSB = 13;
   localparam int SRC_W = 2;
   localparam int DLY_LSB = 0;
   localparam int DLY_W = 6;
   localparam int CUT_LSB = 0;
   localparam int CUT_W = 3;

   // ----------------------------------------
   // Reset values and codes
   // ----------------------------------------
   localparam logic [CUT_W-1:0] RST_CUT = 3'h2;
   localparam logic [OSR_W-1:0] RST_OSR = 2'h1;
   localparam logic [SUP_W-1:0] RST_SUP = 2'h0;
   localparam logic [GAIN_W-1:0] RST_GAIN = 7'h40;
   localparam logic [SRC_W-1:0] RST_SRC = 2'h0;
   localparam logic [DLY_W-1:0] RST_DLY = 6'h00;
   localparam logic [GAIN_W-1:0] GAIN_MIN_CODE = 7'h40;
   localparam logic [GAIN_W-1:0] GAIN_MAX_CODE = 7'h5F;
   localparam logic [OSR_W-1:0] OSR_LOW_POWER = 2'h0;
   localparam logic [OSR_W-1:0] OSR_HIGH_PERF = 2'h1;
   localparam logic [OSR_W-1:0] MCLK_CODE_1536 = 2'h0;
   localparam logic [OSR_W-1:0] MCLK_CODE_3072 = 2'h1;
   localparam logic [OSR_W-1:0] MCLK_CODE_768 = 2'h3;
   localparam logic [CUT_W-1:0] CUT_MAX_CODE = 3'h4;

   typedef enum logic [3:0] {
      REG_NONE = 4'h0,
      REG_HPF_CUT = 4'h1,
      REG_P1_SHARED = 4'h2,
      REG_P1R_CTRL = 4'h3,
      REG_P1R_VOLSRC = 4'h4,
      REG_P1R_DELAY = 4'h5,
      REG_P2_CTRL = 4'h6,
      REG_P2_VOLSRC = 4'h7,
      REG_P2_DELAY = 4'h8
   } reg_id_t;

   typedef enum logic [2:0] {
      MIC_CLK_OFF = 3'h0,
      MIC_CLK_1536 = 3'h1,
      MIC_CLK_3072 = 3'h2,
      MIC_CLK_768 = 3'h3,
      MIC_CLK_RSVD = 3'h4
   } mic_clk_t;

   typedef struct packed {
      logic [CUT_W-1:0] hpfCut;
      logic p1Digital;
      logic [OSR_W-1:0] p1Osr;
      logic p1rHpf;
      logic [GAIN_W-1:0] p1rGain;
      logic [SRC_W-1:0] p1rSrc;
      logic [DLY_W-1:0] p1rDly;
      logic p2Hpf;
      logic [OSR_W-1:0] p2Osr;
      logic [SUP_W-1:0] p2Sup;
      logic p2Digital;
      logic [GAIN_W-1:0] p2Gain;
      logic [SRC_W-1:0] p2Src;
      logic [DLY_W-1:0] p2Dly;
   } cfg_t;

   typedef struct packed {
      logic hpfEn;
      logic [4:0] gainDb;
      logic gainValid;
      logic srcSecondPair;
      logic srcSingleEnded;
      logic digital;
      logic [DLY_W-1:0] delay;
   } path_ctl_t;

   localparam cfg_t CFG_RST = '{hpfCut: RST_CUT, p1Digital: 1'b0, p1Osr: RST_OSR,
      p1rHpf: 1'b0, p1rGain: RST_GAIN, p1rSrc: RST_SRC, p1rDly: RST_DLY,
      p2Hpf: 1'b0, p2Osr: RST_OSR, p2Sup: RST_SUP, p2Digital: 1'b0,
      p2Gain: RST_GAIN, p2Src: RST_SRC, p2Dly: RST_DLY};

endpackage : input_path_cfg_pkg

// [hdl/pga_gain_decode.sv]
`timescale 1ns/1ps
module pga_gain_decode
   import input_path_cfg_pkg::*;
(
   // Gain code in
   input wire logic [GAIN_W-1:0] code,
   // Decoded gain
   output logic [4:0] gainDb,
   output logic valid
);

   // ----------------------------------------
   // One dB per code above the 0 dB code
   // ----------------------------------------
   always_comb begin
      valid = (code >= GAIN_MIN_CODE) && (code <= GAIN_MAX_CODE);
      gainDb = valid ? 5'(code - GAIN_MIN_CODE) : 5'h00;
   end

endmodule : pga_gain_decode

// [hdl/mic_delay_line.sv]
`timescale 1ns/1ps
module mic_delay_line
   import input_path_cfg_pkg::*;
#(
   parameter int SAMPLE_W = 24,
   parameter int DEPTH = 64
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Control
   input wire logic enable,
   input wire logic [DLY_W-1:0] delay,
   // Samples
   input wire logic inValid,
   input wire logic [SAMPLE_W-1:0] inData,
   output logic outValid,
   output logic [SAMPLE_W-1:0] outData
);

   localparam int PTR_W = $clog2(DEPTH);

   if (DEPTH < 64 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
      $error("DEPTH must be a power of two of at least 64");
   end

   typedef struct packed {
      logic [PTR_W-1:0] wp;
      logic [PTR_W:0] fill;
      logic outValid;
      logic [SAMPLE_W-1:0] outData;
   } state_t;

   state_t st_r;
   state_t st_nxt;
   logic [SAMPLE_W-1:0] mem [DEPTH];
   logic [PTR_W-1:0] eff;
   logic [PTR_W-1:0] rdPtr;

   // ----------------------------------------
   // Ring buffer; a new delay code only moves the read tap
   // ----------------------------------------
   always_comb begin
      st_nxt = st_r;
      eff = enable ? PTR_W'(delay) : '0;
      rdPtr = st_r.wp - eff;
      st_nxt.outValid = inValid;
      if (inValid) begin
         st_nxt.wp = st_r.wp + 1'b1;
         if (st_r.fill != (PTR_W + 1)'(DEPTH)) begin
            st_nxt.fill = st_r.fill + 1'b1;
         end
         // Unwritten history reads as silence, not as unknowns
         if (eff == '0) begin
            st_nxt.outData = inData;
         end else if ((PTR_W + 1)'(eff) > st_r.fill) begin
            st_nxt.outData = '0;
         end else begin
            st_nxt.outData = mem[rdPtr];
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (inValid) begin
         mem[st_r.wp] <= inData;
      end
   end

   assign outValid = st_r.outValid;
   assign outData = st_r.outData;

   a_zero_delay: assert property (@(posedge clk) disable iff (rst)
      (inValid && (!enable || delay == '0)) |=> (outValid && outData == $past(inData)))
      else $error("undelayed sample not passed through");

   a_out_follows: assert property (@(posedge clk) disable iff (rst)
      outValid == $past(inValid))
      else $error("output valid not one cycle after input valid");

endmodule : mic_delay_line

// [hdl/input_path_config_bank.sv]
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ps
// How it works
// - Bit 15 of the path one right control word enables its high-pass filter, reset off.
// - Path one right gain code 40h to 5Fh gives 0 to 31 dB in 1 dB steps, reset 40h.
// - Path one right source field picks pair and differential or single-ended, reset 00.
// - Path one right mic samples are delayed 0 to 63 samples, only in digital mode.
// - Bit 15 of the path two control word enables its high-pass filter, reset off.
// - In analogue mode the path two rate field picks low power or high performance.
// - In digital mode the path two rate field picks a 1.536, 3.072 or 0.768 MHz mic clock.
// - The path two reference select is output as written, reset 00.
// - Path two mode bit 10 selects analogue (0) or digital mic (1) input, reset 0.
// - Path two gain code 40h to 5Fh gives 0 to 31 dB in 1 dB steps, reset 40h.
// - Path two source field picks pair and differential or single-ended, reset 00.
// - Path two mic samples are delayed 0 to 63 samples, only in digital mode.
// - The shared path one mode bit also sets the right channel to analogue or digital.
// - A shared 3-bit code sets the cut-off of all high-pass filters; codes above 100 reserved.
module input_path_config_bank
   import input_path_cfg_pkg::*;
#(
   parameter int ADR_W = 14,
   parameter int SAMPLE_W = 24,
   parameter int DELAY_DEPTH = 64
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [ADR_W-1:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Path one right samples
   input wire logic p1rSampleValid,
   input wire logic [SAMPLE_W-1:0] p1rSampleIn,
   output logic p1rSampleOutValid,
   output logic [SAMPLE_W-1:0] p1rSampleOut,
   // Path two samples
   input wire logic p2SampleValid,
   input wire logic [SAMPLE_W-1:0] p2SampleIn,
   output logic p2SampleOutValid,
   output logic [SAMPLE_W-1:0] p2SampleOut,
   // Decoded configuration
   output path_ctl_t p1rCtl,
   output path_ctl_t p2Ctl,
   output logic [CUT_W-1:0] highpassCutoffSel,
   output logic highpassCutoffValid,
   output mic_clk_t p1MicClock,
   output mic_clk_t p2MicClock,
   output logic p2LowPower,
   output logic p2PerfHigh,
   output logic [SUP_W-1:0] p2MicRefSel
);

   if (ADR_W < 14) begin : g_chk
      $error("ADR_W must be at least 14");
   end

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      cfg_t cfg;
      logic ack;
      logic [31:0] rdata;
      path_ctl_t p1r;
      path_ctl_t p2;
      logic [CUT_W-1:0] cut;
      logic cutOk;
      mic_clk_t clk1;
      mic_clk_t clk2;
      logic lowPow;
      logic perfHi;
      logic [SUP_W-1:0] refSel;
   } state_t;

   state_t st_r;
   state_t st_nxt;
   reg_id_t regId;
   logic access;
   logic [15:0] wrWord;
   logic [4:0] p1rGainDb;
   logic p1rGainOk;
   logic [4:0] p2GainDb;
   logic p2GainOk;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic reg_id_t regSelect(input logic [ADR_W-1:0] a);
      logic [ADR_W-3:0] idx;
      idx = a[ADR_W-1:2];
      if (idx == (ADR_W - 2)'(IDX_HPF_CUT)) begin
         return REG_HPF_CUT;
      end else if (idx == (ADR_W - 2)'(IDX_P1_SHARED)) begin
         return REG_P1_SHARED;
      end else if (idx == (ADR_W - 2)'(IDX_P1R_CTRL)) begin
         return REG_P1R_CTRL;
      end else if (idx == (ADR_W - 2)'(IDX_P1R_VOLSRC)) begin
         return REG_P1R_VOLSRC;
      end else if (idx == (ADR_W - 2)'(IDX_P1R_DELAY)) begin
         return REG_P1R_DELAY;
      end else if (idx == (ADR_W - 2)'(IDX_P2_CTRL)) begin
         return REG_P2_CTRL;
      end else if (idx == (ADR_W - 2)'(IDX_P2_VOLSRC)) begin
         return REG_P2_VOLSRC;
      end else if (idx == (ADR_W - 2)'(IDX_P2_DELAY)) begin
         return REG_P2_DELAY;
      end else begin
         return REG_NONE;
      end
   endfunction : regSelect

   // Only held fields are placed; every other bit reads zero
   function automatic logic [15:0] regRead(input cfg_t c, input reg_id_t id);
      logic [15:0] w;
      w = 16'h0000;
      case (id)
         REG_HPF_CUT: w[CUT_LSB +: CUT_W] = c.hpfCut;
         REG_P1_SHARED: begin
            w[OSR_LSB +: OSR_W] = c.p1Osr;
            w[MODE_BIT] = c.p1Digital;
         end
         REG_P1R_CTRL: begin
            w[HPF_EN_BIT] = c.p1rHpf;
            w[GAIN_LSB +: GAIN_W] = c.p1rGain;
         end
         REG_P1R_VOLSRC: w[SRC_LSB +: SRC_W] = c.p1rSrc;
         REG_P1R_DELAY: w[DLY_LSB +: DLY_W] = c.p1rDly;
         REG_P2_CTRL: begin
            w[HPF_EN_BIT] = c.p2Hpf;
            w[OSR_LSB +: OSR_W] = c.p2Osr;
            w[SUP_LSB +: SUP_W] = c.p2Sup;
            w[MODE_BIT] = c.p2Digital;
            w[GAIN_LSB +: GAIN_W] = c.p2Gain;
         end
         REG_P2_VOLSRC: w[SRC_LSB +: SRC_W] = c.p2Src;
         REG_P2_DELAY: w[DLY_LSB +: DLY_W] = c.p2Dly;
         default: w = 16'h0000;
      endcase
      return w;
   endfunction : regRead

   function automatic mic_clk_t micClock(input logic dig, input logic [OSR_W-1:0] osr);
      if (!dig) begin
         return MIC_CLK_OFF;
      end else if (osr == MCLK_CODE_1536) begin
         return MIC_CLK_1536;
      end else if (osr == MCLK_CODE_3072) begin
         return MIC_CLK_3072;
      end else if (osr == MCLK_CODE_768) begin
         return MIC_CLK_768;
      end else begin
         return MIC_CLK_RSVD;
      end
   endfunction : micClock

   // ----------------------------------------
   // Gain decoders
   // ----------------------------------------
   pga_gain_decode u_p1r_gain (
      .code(st_r.cfg.p1rGain),
      .gainDb(p1rGainDb),
      .valid(p1rGainOk)
   );

   pga_gain_decode u_p2_gain (
      .code(st_r.cfg.p2Gain),
      .gainDb(p2GainDb),
      .valid(p2GainOk)
   );

   // ----------------------------------------
   // Bus access and decode
   // ----------------------------------------
   always_comb begin
      st_nxt = st_r;
      regId = regSelect(adr_i);
      access = cyc_i && stb_i;
      // Byte lanes above the low half carry nothing
      wrWord = regRead(st_r.cfg, regId);
      if (sel_i[0]) begin
         wrWord[7:0] = dat_i[7:0];
      end
      if (sel_i[1]) begin
         wrWord[15:8] = dat_i[15:8];
      end
      st_nxt.ack = access && !st_r.ack;
      if (access && !st_r.ack) begin
         st_nxt.rdata = {16'h0000, regRead(st_r.cfg, regId)};
      end
      // Write lands on the edge that the master samples ack
      if (access && st_r.ack && we_i) begin
         case (regId)
            REG_HPF_CUT: st_nxt.cfg.hpfCut = wrWord[CUT_LSB +: CUT_W];
            REG_P1_SHARED: begin
               st_nxt.cfg.p1Osr = wrWord[OSR_LSB +: OSR_W];
               st_nxt.cfg.p1Digital = wrWord[MODE_BIT];
            end
            REG_P1R_CTRL: begin
               st_nxt.cfg.p1rHpf = wrWord[HPF_EN_BIT];
               st_nxt.cfg.p1rGain = wrWord[GAIN_LSB +: GAIN_W];
            end
            REG_P1R_VOLSRC: st_nxt.cfg.p1rSrc = wrWord[SRC_LSB +: SRC_W];
            REG_P1R_DELAY: st_nxt.cfg.p1rDly = wrWord[DLY_LSB +: DLY_W];
            REG_P2_CTRL: begin
               st_nxt.cfg.p2Hpf = wrWord[HPF_EN_BIT];
               st_nxt.cfg.p2Osr = wrWord[OSR_LSB +: OSR_W];
               st_nxt.cfg.p2Sup = wrWord[SUP_LSB +: SUP_W];
               st_nxt.cfg.p2Digital = wrWord[MODE_BIT];
               st_nxt.cfg.p2Gain = wrWord[GAIN_LSB +: GAIN_W];
            end
            REG_P2_VOLSRC: st_nxt.cfg.p2Src = wrWord[SRC_LSB +: SRC_W];
            REG_P2_DELAY: st_nxt.cfg.p2Dly = wrWord[DLY_LSB +: DLY_W];
            default: st_nxt.cfg = st_r.cfg;
         endcase
      end
      // Gain only counts for analogue input; reserved codes give no gain
      st_nxt.p1r.hpfEn = st_r.cfg.p1rHpf;
      st_nxt.p1r.gainDb = p1rGainDb;
      st_nxt.p1r.gainValid = p1rGainOk && !st_r.cfg.p1Digital;
      st_nxt.p1r.srcSecondPair = st_r.cfg.p1rSrc[1];
      st_nxt.p1r.srcSingleEnded = st_r.cfg.p1rSrc[0];
      st_nxt.p1r.digital = st_r.cfg.p1Digital;
      st_nxt.p1r.delay = st_r.cfg.p1rDly;
      st_nxt.p2.hpfEn = st_r.cfg.p2Hpf;
      st_nxt.p2.gainDb = p2GainDb;
      st_nxt.p2.gainValid = p2GainOk && !st_r.cfg.p2Digital;
      st_nxt.p2.srcSecondPair = st_r.cfg.p2Src[1];
      st_nxt.p2.srcSingleEnded = st_r.cfg.p2Src[0];
      st_nxt.p2.digital = st_r.cfg.p2Digital;
      st_nxt.p2.delay = st_r.cfg.p2Dly;
      st_nxt.cut = st_r.cfg.hpfCut;
      st_nxt.cutOk = st_r.cfg.hpfCut <= CUT_MAX_CODE;
      st_nxt.clk1 = micClock(st_r.cfg.p1Digital, st_r.cfg.p1Osr);
      st_nxt.clk2 = micClock(st_r.cfg.p2Digital, st_r.cfg.p2Osr);
      st_nxt.lowPow = !st_r.cfg.p2Digital && st_r.cfg.p2Osr == OSR_LOW_POWER;
      st_nxt.perfHi = !st_r.cfg.p2Digital && st_r.cfg.p2Osr == OSR_HIGH_PERF;
      st_nxt.refSel = st_r.cfg.p2Sup;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r <= '0;
         st_r.cfg <= CFG_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------
   // Mic sample delays
   // ----------------------------------------
   mic_delay_line #(
      .SAMPLE_W(SAMPLE_W),
      .DEPTH(DELAY_DEPTH)
   ) u_p1r_delay (
      .clk(clk),
      .rst(rst),
      .enable(st_r.p1r.digital),
      .delay(st_r.p1r.delay),
      .inValid(p1rSampleValid),
      .inData(p1rSampleIn),
      .outValid(p1rSampleOutValid),
      .outData(p1rSampleOut)
   );

   mic_delay_line #(
      .SAMPLE_W(SAMPLE_W),
      .DEPTH(DELAY_DEPTH)
   ) u_p2_delay (
      .clk(clk),
      .rst(rst),
      .enable(st_r.p2.digital),
      .delay(st_r.p2.delay),
      .inValid(p2SampleValid),
      .inData(p2SampleIn),
      .outValid(p2SampleOutValid),
      .outData(p2SampleOut)
   );

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign dat_o = st_r.rdata;
   assign ack_o = st_r.ack;
   assign p1rCtl = st_r.p1r;
   assign p2Ctl = st_r.p2;
   assign highpassCutoffSel = st_r.cut;
   assign highpassCutoffValid = st_r.cutOk;
   assign p1MicClock = st_r.clk1;
   assign p2MicClock = st_r.clk2;
   assign p2LowPower = st_r.lowPow;
   assign p2PerfHigh = st_r.perfHi;
   assign p2MicRefSel = st_r.refSel;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_hpf_write: assert property (@(posedge clk) disable iff (rst)
      (cyc_i && stb_i && we_i && ack_o && sel_i[1] && regSelect(adr_i) == REG_P1R_CTRL)
      |=> ##1 (p1rCtl.hpfEn == $past(dat_i[HPF_EN_BIT], 2)))
      else $error("path one right filter enable not written");

   a_gain_zero: assert property (@(posedge clk) disable iff (rst)
      (st_r.cfg.p1rGain == GAIN_MIN_CODE && !st_r.cfg.p1Digital)
      |=> (p1rCtl.gainValid && p1rCtl.gainDb == 5'h00))
      else $error("gain code 40h not decoded as 0 dB");

   a_gain_top: assert property (@(posedge clk) disable iff (rst)
      (st_r.cfg.p2Gain == GAIN_MAX_CODE && !st_r.cfg.p2Digital)
      |=> (p2Ctl.gainValid && p2Ctl.gainDb == 5'h1F))
      else $error("gain code 5Fh not decoded as 31 dB");

   a_src_follow: assert property (@(posedge clk) disable iff (rst)
      p1rCtl.srcSecondPair == $past(st_r.cfg.p1rSrc[1]))
      else $error("source pair select does not follow field");

   a_low_power: assert property (@(posedge clk) disable iff (rst)
      (!st_r.cfg.p2Digital && st_r.cfg.p2Osr == OSR_LOW_POWER) |=> (p2LowPower && !p2PerfHigh))
      else $error("low power mode not decoded");

   a_slow_clock: assert property (@(posedge clk) disable iff (rst)
      (st_r.cfg.p2Digital && st_r.cfg.p2Osr == MCLK_CODE_768) |=> (p2MicClock == MIC_CLK_768))
      else $error("slow mic clock not decoded");

   a_mode_two: assert property (@(posedge clk) disable iff (rst)
      $rose(st_r.cfg.p2Digital) |=> (p2Ctl.digital && !p2Ctl.gainValid))
      else $error("path two digital mode not applied");

   a_cut_reserved: assert property (@(posedge clk) disable iff (rst)
      (st_r.cfg.hpfCut > CUT_MAX_CODE) |=> !highpassCutoffValid)
      else $error("reserved cut-off code flagged valid");

   a_read_back: assert property (@(posedge clk) disable iff (rst)
      (cyc_i && stb_i && !we_i && !ack_o && regSelect(adr_i) == REG_P2_DELAY)
      |=> (ack_o && dat_o == {26'h0, st_r.cfg.p2Dly}))
      else $error("delay field read back wrong");

   a_ack_pulse: assert property (@(posedge clk) disable iff (rst)
      ack_o |=> !ack_o)
      else $error("ack held longer than one cycle");

endmodule : input_path_config_bank

// [test/tb.sv]
`timescale 1ns/1ps
module tb;
   import input_path_cfg_pkg::*;
   logic clk, rst, cyc, stb, we, ack_o, v1, v2, ov1, ov2;
   logic [13:0] adr;
   logic [3:0] sel;
   logic [31:0] dat, dat_o;
   logic [23:0] s1, s2, o1, o2;
   path_ctl_t p1rCtl, p2Ctl;
   logic [2:0] cut;
   logic cutValid, lowPow, perfHi;
   mic_clk_t mc1, mc2;
   logic [1:0] refSel;
   int n_errors = 0, cmp_count = 0, e1, e2;
   logic [31:0] rq[$], q1[$], q2[$];
   logic [23:0] h[$];
   logic [11:0] idx[8] = '{12'h30C, 12'h310, 12'h314, 12'h315, 12'h316, 12'h318, 12'h319, 12'h31A};
   logic [15:0] rv[8] = '{16'h0002, 16'h2000, 16'h0080, 16'h0, 16'h0, 16'h2080, 16'h0, 16'h0};
   logic [15:0] mk[8] = '{16'h0007, 16'h6400, 16'h80FE, 16'h6000, 16'h003F, 16'hFCFE,
      16'h6000, 16'h003F};
   mic_clk_t ct[4] = '{MIC_CLK_1536, MIC_CLK_3072, MIC_CLK_RSVD, MIC_CLK_768};
   input_path_config_bank dut (.clk(clk), .rst(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
      .p1rSampleValid(v1), .p1rSampleIn(s1), .p1rSampleOutValid(ov1), .p1rSampleOut(o1),
      .p2SampleValid(v2), .p2SampleIn(s2), .p2SampleOutValid(ov2), .p2SampleOut(o2),
      .p1rCtl(p1rCtl), .p2Ctl(p2Ctl), .highpassCutoffSel(cut), .highpassCutoffValid(cutValid),
      .p1MicClock(mc1), .p2MicClock(mc2), .p2LowPower(lowPow), .p2PerfHigh(perfHi),
      .p2MicRefSel(refSel));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      cmp_count++;
      if (got !== ex) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, ex, got);
      end
   endtask : chk
   task automatic stop_test;
      $display("Comparisons %0d, errors %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : stop_test
   // Bus request held until ack, then released for a cycle
   task automatic bus(input logic w, input logic [11:0] a, input logic [15:0] d);
      int t;
      t = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {a, 2'h0};
      sel <= 4'hF;
      dat <= {16'($urandom), d};
      do begin
         @(posedge clk);
         t++;
      end while (ack_o !== 1'b1 && t < 50);
      if (t >= 50) chk("ack", 32'h1, 32'h0);
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : bus
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      bus(1'b1, a, d);
      repeat (3) @(posedge clk);
      #1;
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [15:0] ex);
      rq.push_back({16'h0, ex});
      bus(1'b0, a, 16'h0);
   endtask : rd
   // Same stream on both paths, back to back strobes
   task automatic stream(input int n);
      logic [23:0] x;
      int i;
      repeat (n) begin
         @(posedge clk);
         x = 24'($urandom);
         v1 <= 1'b1;
         v2 <= 1'b1;
         s1 <= x;
         s2 <= x;
         h.push_back(x);
         i = h.size() - 1;
         q1.push_back(i >= e1 ? {8'h0, h[i-e1]} : 32'h0);
         q2.push_back(i >= e2 ? {8'h0, h[i-e2]} : 32'h0);
      end
      @(posedge clk);
      v1 <= 1'b0;
      v2 <= 1'b0;
   endtask : stream
   // ----------------------------------------
   // Result watcher
   // ----------------------------------------
   always @(posedge clk) begin
      if (ack_o === 1'b1 && we === 1'b0) chk("rdata", rq.pop_front(), dat_o);
      if (ov1 === 1'b1) chk("p1r_sample", q1.pop_front(), {8'h0, o1});
      if (ov2 === 1'b1) chk("p2_sample", q2.pop_front(), {8'h0, o2});
   end
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      #200000;
      n_errors++;
      stop_test();
   end
   initial begin
      logic [15:0] d;
      {cyc, stb, we, v1, v2} = '0;
      adr = '0;
      sel = '0;
      dat = '0;
      s1 = '0;
      s2 = '0;
      rst = 1'b1;
      void'($urandom(32'h78c0874f));
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 8; i++) rd(idx[i], rv[i]);
      rd(12'h320, 16'h0);
      for (int k = 0; k < 24; k++) begin
         d = 16'($urandom);
         bus(1'b1, idx[k%8], d);
         rd(idx[k%8], d & mk[k%8]);
      end
      // ----------------------------------------
      // Decoded outputs
      // ----------------------------------------
      wr(12'h310, 16'h0);
      wr(12'h318, 16'h908A);
      chk("p2_ctl", 8'h96, {p2Ctl.hpfEn, p2Ctl.gainDb, p2Ctl.gainValid, p2Ctl.digital});
      chk("p2_power", 4'hA, {lowPow, perfHi, refSel});
      chk("p2_clk", 32'(MIC_CLK_OFF), 32'(mc2));
      for (int o = 0; o < 4; o++) begin
         wr(12'h318, 16'h0400 | 16'(o << 13));
         chk("p2_mclk", 32'(ct[o]), 32'(mc2));
         chk("p2_dig", 2'h2, {p2Ctl.digital, p2Ctl.gainValid});
      end
      wr(12'h30C, 16'h5);
      chk("cut_rsvd", 4'hA, {1'b0, cut, cutValid});
      wr(12'h30C, 16'h4);
      chk("cut_max", 4'h9, {cut, cutValid});
      wr(12'h314, 16'h80BE);
      chk("p1r_gain", 7'h7F, {p1rCtl.hpfEn, p1rCtl.gainDb, p1rCtl.gainValid});
      wr(12'h315, 16'h4000);
      chk("p1r_src", 2'h2, {p1rCtl.srcSecondPair, p1rCtl.srcSingleEnded});
      wr(12'h319, 16'h6000);
      chk("p2_src", 2'h3, {p2Ctl.srcSecondPair, p2Ctl.srcSingleEnded});
      wr(12'h318, 16'h00BE);
      chk("p2_gain", 6'h3F, {p2Ctl.gainDb, p2Ctl.gainValid});
      // ----------------------------------------
      // Delay lines
      // ----------------------------------------
      wr(12'h310, 16'h0400);
      wr(12'h318, 16'h0400);
      wr(12'h316, 16'h5);
      wr(12'h31A, 16'h3);
      e1 = 5;
      e2 = 3;
      chk("p1_mclk", 32'(MIC_CLK_1536), 32'(mc1));
      chk("dly", 13'h0287, {p1rCtl.delay, p2Ctl.delay, p1rCtl.digital});
      stream(10);
      wr(12'h31A, 16'h3F);
      e2 = 63;
      stream(70);
      wr(12'h310, 16'h0);
      e1 = 0;
      stream(4);
      repeat (3) @(posedge clk);
      // Mid-run reset brings every field back to its reset value
      rst <= 1'b1;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 8; i++) rd(idx[i], rv[i]);
      #1;
      chk("rst_dec", 6'h25, {perfHi, lowPow, cut, cutValid});
      chk("queues", 32'h0, 32'(q1.size() + q2.size() + rq.size()));
      stop_test();
   end
endmodule : tb
